/* testbench/pmm_core_model.sv */
// Core model that steps the program counter while running
`timescale 1ns/1ps
module pmm_core_model (
  input wire logic clk, core_rst, run,
  output logic     pc_step
);
  // Core stays quiet in reset
  always_ff @(posedge clk) begin
    pc_step <= run & ~core_rst;
  end
endmodule // pmm_core_model

/* testbench/pmm_props.sv */
// Port-level properties of the program memory map block
`timescale 1ns/1ps
module pmm_props #(parameter int FLASH_KB = 128) (
  input wire logic        clk, rst, reset_req, pc_step, pc_write, wake_irq, wake_irq_high,
  input wire logic        global_irq_enable_high, global_irq_enable_low, core_rst,
  input wire logic [20:0] pc,
  input wire logic [7:0]  pc_low_byte, stack_top_high, stack_top_low,
  input wire logic [15:0] fetch_data,
  input wire logic [4:0]  stack_top_upper, stack_pointer
);
  localparam logic [20:0] TOP = 21'(FLASH_KB * 1024);
  logic go, wk;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign go = !core_rst && !reset_req;
  assign wk = go && wake_irq && (global_irq_enable_high || global_irq_enable_low);
  ////////////////////////////////////////////////////////////////////////////////
  property p_step; go && pc_step && !wake_irq && !pc_write |=> pc == $past(pc) + 21'h2; endproperty
  a_step: assert property (p_step) else $error("pc step wrong");
  property p_vec_hi; wk && wake_irq_high |=> pc == 21'h8; endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("high vector wrong");
  property p_vec_lo; wk && !wake_irq_high |=> pc == 21'h18; endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("low vector wrong");
  property p_push; wk |=> {stack_top_upper, stack_top_high, stack_top_low} == $past(pc); endproperty
  a_push: assert property (p_push) else $error("stack top wrong");
  property p_sp; wk && stack_pointer != 5'h1F |=> stack_pointer == $past(stack_pointer) + 5'h1;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer wrong");
  property p_bit0; pc[0] == 1'b0 && pc_low_byte == pc[7:0]; endproperty
  a_bit0: assert property (p_bit0) else $error("pc alignment wrong");
  property p_above; go && pc >= TOP |=> fetch_data == 16'h0000; endproperty
  a_above: assert property (p_above) else $error("read above top not zero");
  property p_rvec; reset_req |=> core_rst && pc == 21'h0; endproperty
  a_rvec: assert property (p_rvec) else $error("reset vector wrong");
  // A one-cycle reset request gives exactly six load cycles, then the core runs
  property p_hold; reset_req ##1 !reset_req |-> core_rst [*6] ##1 !core_rst; endproperty
  a_hold: assert property (p_hold) else $error("core reset span wrong");
  property p_quiet; go && wake_irq && !global_irq_enable_high && !global_irq_enable_low
    && !pc_write && !pc_step |=> pc == $past(pc); endproperty
  a_quiet: assert property (p_quiet) else $error("disabled wake moved pc");
  c_wake: cover property (wk);
  c_above: cover property (go && pc >= TOP);
  c_boot: cover property ($fell(core_rst));
endmodule // pmm_props

/* testbench/test_program_memory_map_config_load.sv */
// Bench for the program memory map and configuration loader
`timescale 1ns/1ps
module test_program_memory_map_config_load;
  logic clk = 0, rst = 1, reset_req = 0, pc_write = 0, wake_irq = 0, wake_irq_high = 0;
  logic global_irq_enable_high = 0, global_irq_enable_low = 0, prog_en = 0, run = 0;
  logic        pc_step, core_rst;
  logic [20:0] pc_write_value = '0, prog_addr = '0, pc;
  logic [15:0] prog_data = '0, fetch_data, config_word_one, config_word_two, config_word_three;
  logic [7:0]  pc_low_byte, stack_top_high, stack_top_low;
  logic [4:0]  stack_top_upper, stack_pointer;
  int          error_cnt = 0, check_count = 0;
  pmm_top #(.FLASH_KB(64)) i_pmm_top (.*);
  pmm_core_model i_pmm_core_model (.*);
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [20:0] e, logic [20:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic prog(logic [20:0] a, logic [15:0] d);
    @(posedge clk) {prog_en, prog_addr, prog_data} <= {1'b1, a, d};
    @(posedge clk) prog_en <= 0;
  endtask
  task automatic boot;
    for (int i = 0; i < 20 && core_rst !== 1'b0; i++) @(posedge clk) #1;
    chk("core_rst", 0, 21'(core_rst));
  endtask
  task automatic jump(logic [20:0] a, logic [20:0] ep, logic [15:0] ef);
    @(posedge clk) {pc_write, pc_write_value} <= {1'b1, a};
    @(posedge clk) pc_write <= 0;
    #1 chk("pc", ep, pc);
    @(posedge clk) #1 chk("fetch", {5'h0, ef}, {5'h0, fetch_data});
  endtask
  task automatic wake(logic h, logic eh, logic el, logic [20:0] ep, logic [4:0] es, logic [20:0] et);
    @(posedge clk) {wake_irq, wake_irq_high, global_irq_enable_high, global_irq_enable_low} <= {1'b1, h, eh, el};
    @(posedge clk) wake_irq <= 0;
    #1 chk("pc", ep, pc);
    chk("sp", {16'h0, es}, {16'h0, stack_pointer});
    chk("tos", et, {stack_top_upper, stack_top_high, stack_top_low});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_load;
    prog(21'h0FFF8, 16'hA1B2);
    prog(21'h0FFFA, 16'hC3D4);
    prog(21'h0FFFC, 16'hE5F6);
    prog(21'h0FFFE, 16'h1234);
    prog(21'h00000, 16'h5A5A);
    prog(21'h00008, 16'h0F0F);
    @(posedge clk) reset_req <= 1;
    @(posedge clk) reset_req <= 0;
    #1 chk("pc", 0, pc);
    boot;
    chk("cfg1", 21'hA1B2, {5'h0, config_word_one});
    chk("cfg2", 21'hC3D4, {5'h0, config_word_two});
    chk("cfg3", 21'hE5F6, {5'h0, config_word_three});
    @(posedge clk) #1 chk("fetch", 21'h5A5A, {5'h0, fetch_data});
  endtask
  task automatic t_fetch;
    jump(21'h0FFFF, 21'h0FFFE, 16'h1234);
    jump(21'h10000, 21'h10000, 16'h0000);
    jump(21'h1FFFFE, 21'h1FFFFE, 16'h0000);
    jump(21'h00008, 21'h00008, 16'h0F0F);
  endtask
  task automatic t_step;
    @(posedge clk) run <= 1;
    repeat (4) @(posedge clk);
    run <= 0;
    repeat (2) @(posedge clk);
    #1 chk("pc", 21'h10, pc);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    boot;
    t_load;
    t_fetch;
    t_step;
    wake(1, 1, 0, 21'h8, 5'h1, 21'h10);
    wake(0, 0, 1, 21'h18, 5'h2, 21'h8);
    wake(1, 0, 0, 21'h18, 5'h2, 21'h8);
    stop_test;
  end
  // Whole run is well under a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule // test_program_memory_map_config_load
bind pmm_top pmm_props #(.FLASH_KB(FLASH_KB)) i_pmm_props (.*);

/* verilog/pmm_flash.sv */
// On-chip flash word array with registered read data
`timescale 1ns/1ps
module pmm_flash #(
  parameter int WORDS = 65536,
  parameter int AW    = 16
) (
  input  wire logic clk,
  pmm_mem_if.mem    bus
);
  logic [15:0] array [WORDS];

  // No reset on the array: contents survive every device reset
  always_ff @(posedge clk) begin
    if (bus.wr_en && (32'(bus.wr_addr) < WORDS)) begin
      array[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    bus.rd_data <= (32'(bus.rd_addr) < WORDS) ? array[bus.rd_addr] : 16'h0000;
  end
endmodule // pmm_flash

/* verilog/pmm_mem_if.sv */
// Flash array access signals between the top and the array
`timescale 1ns/1ps
interface pmm_mem_if #(
  parameter int AW = 16
);
  logic [AW-1:0] rd_addr;
  logic [15:0]   rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [15:0]   wr_data;
  modport host (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

/* verilog/pmm_pkg.sv */
// Constants for the program memory map and configuration loader
package pmm_pkg;
  localparam int          ADDR_W          = 21;
  localparam int          WORD_W          = 16;
  localparam int          BYTE_W          = 8;
  localparam int          FLASH_KB_DEF    = 128;
  localparam int          KB_BYTES        = 1024;
  localparam logic [20:0] RESET_VECTOR    = 21'h000000;
  localparam logic [20:0] IRQ_HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] IRQ_LOW_VECTOR  = 21'h000018;
  localparam logic [20:0] PC_STEP         = 21'h000002;
  localparam logic [20:0] CFG_AREA_BYTES  = 21'h000008;
  localparam logic [1:0]  CFG_WORDS_USED  = 2'h3;
  localparam int          SP_W            = 5;
  localparam logic [4:0]  SP_RESET        = 5'h00;
  localparam logic [4:0]  STACK_DEPTH     = 5'h1F;
  localparam logic [15:0] CFG_RESET       = 16'hFFFF;
  localparam logic [15:0] NO_OPERATION    = 16'h0000;
  localparam int          TOS_UPPER_LSB   = 16;
  localparam int          TOS_HIGH_LSB    = 8;
endpackage

/* verilog/pmm_top.sv */
// Program memory map, hard vectors and reset-time configuration load
`timescale 1ns/1ps
module pmm_top #(
  parameter int FLASH_KB = pmm_pkg::FLASH_KB_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reset_req,
  input  wire logic        pc_step,
  input  wire logic        pc_write,
  input  wire logic [20:0] pc_write_value,
  input  wire logic        wake_irq,
  input  wire logic        wake_irq_high,
  input  wire logic        global_irq_enable_high,
  input  wire logic        global_irq_enable_low,
  input  wire logic        prog_en,
  input  wire logic [20:0] prog_addr,
  input  wire logic [15:0] prog_data,
  output logic             core_rst,
  output logic [20:0]      pc,
  output logic [7:0]       pc_low_byte,
  output logic [15:0]      fetch_data,
  output logic [4:0]       stack_top_upper,
  output logic [7:0]       stack_top_high,
  output logic [7:0]       stack_top_low,
  output logic [4:0]       stack_pointer,
  output logic [15:0]      config_word_one,
  output logic [15:0]      config_word_two,
  output logic [15:0]      config_word_three
);
  ////////////////////////////////////////////////////////////////////////
  // Memory map
  localparam int          FLASH_BYTES = FLASH_KB * pmm_pkg::KB_BYTES;
  localparam int          WORDS       = FLASH_BYTES / 2;
  localparam int          WAW         = $clog2(WORDS);
  localparam logic [20:0] TOP_OF_MEM  = 21'(FLASH_BYTES);
  localparam logic [20:0] CFG_BASE    = TOP_OF_MEM - pmm_pkg::CFG_AREA_BYTES;

  typedef enum logic [1:0] {PMM_LD_ISSUE, PMM_LD_CAPTURE, PMM_LD_DONE} pmm_ld_t;

  pmm_ld_t          ld_state;
  logic [1:0]       ld_idx;
  logic             fetch_oor;
  logic [20:0]      stack_top;
  logic [WAW-1:0]   cfg_word_addr;

  pmm_mem_if #(.AW(WAW)) mif ();

  pmm_flash #(
    .WORDS (WORDS),
    .AW    (WAW)
  ) u_flash (
    .clk (clk),
    .bus (mif.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // Flash read port: loader owns it while the core is held, then the PC; writes follow prog_en
  // Program fetch path touches nothing on the data RAM side
  assign cfg_word_addr = WAW'(CFG_BASE[20:1]) + WAW'(ld_idx);
  assign mif.rd_addr   = (ld_state == PMM_LD_DONE) ? pc[WAW:1] : cfg_word_addr;
  assign mif.wr_en     = prog_en && (prog_addr < TOP_OF_MEM);
  assign mif.wr_addr   = prog_addr[WAW:1];
  assign mif.wr_data   = prog_data;

  ////////////////////////////////////////////////////////////////////////
  // Out-of-range flag travels with the registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_oor <= 1'b0;
    end else begin
      fetch_oor <= (pc >= TOP_OF_MEM);
    end
  end

  // Above top of flash the core sees a no-operation word
  assign fetch_data = fetch_oor ? pmm_pkg::NO_OPERATION : mif.rd_data;

  ////////////////////////////////////////////////////////////////////////
  // Configuration loader: one issue and one capture cycle per word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_state <= PMM_LD_ISSUE;
      ld_idx   <= 2'h0;
    end else if (reset_req) begin
      ld_state <= PMM_LD_ISSUE;
      ld_idx   <= 2'h0;
    end else begin
      unique case (ld_state)
        PMM_LD_ISSUE: begin
          ld_state <= PMM_LD_CAPTURE;
        end
        PMM_LD_CAPTURE: begin
          // Word four is never read: it is reserved
          if (ld_idx == pmm_pkg::CFG_WORDS_USED - 2'h1) begin
            ld_state <= PMM_LD_DONE;
          end else begin
            ld_state <= PMM_LD_ISSUE;
            ld_idx   <= ld_idx + 2'h1;
          end
        end
        PMM_LD_DONE: begin
          ld_state <= PMM_LD_DONE;
        end
      endcase
    end
  end

  // Low byte sits at the even address, so the word lands as stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_word_one   <= pmm_pkg::CFG_RESET;
      config_word_two   <= pmm_pkg::CFG_RESET;
      config_word_three <= pmm_pkg::CFG_RESET;
    end else if (ld_state == PMM_LD_CAPTURE) begin
      unique case (ld_idx)
        2'h0:    config_word_one   <= mif.rd_data;
        2'h1:    config_word_two   <= mif.rd_data;
        default: config_word_three <= mif.rd_data;
      endcase
    end
  end

  // Core stays reset so the first fetch sees loaded configuration
  assign core_rst = rst || (ld_state != PMM_LD_DONE);

  ////////////////////////////////////////////////////////////////////////
  // Program counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= pmm_pkg::RESET_VECTOR;
    end else if (reset_req || (ld_state != PMM_LD_DONE)) begin
      pc <= pmm_pkg::RESET_VECTOR;
    end else if (wake_irq && (global_irq_enable_high || global_irq_enable_low)) begin
      pc <= wake_irq_high ? pmm_pkg::IRQ_HIGH_VECTOR
                          : pmm_pkg::IRQ_LOW_VECTOR;
    end else if (pc_write) begin
      pc <= {pc_write_value[20:1], 1'b0};
    end else if (pc_step) begin
      pc <= pc + pmm_pkg::PC_STEP;
    end
  end

  assign pc_low_byte = pc[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Top of stack and stack pointer on interrupt wake-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_top     <= 21'h000000;
      stack_pointer <= pmm_pkg::SP_RESET;
    end else if (reset_req || (ld_state != PMM_LD_DONE)) begin
      stack_top     <= 21'h000000;
      stack_pointer <= pmm_pkg::SP_RESET;
    end else if (wake_irq && (global_irq_enable_high || global_irq_enable_low)) begin
      stack_top <= pc;
      // Saturates at the last entry, 5'h1F, and holds there
      if (stack_pointer != pmm_pkg::STACK_DEPTH) begin
        stack_pointer <= stack_pointer + 5'h01;
      end
    end
  end

  assign stack_top_upper = stack_top[20:pmm_pkg::TOS_UPPER_LSB];
  assign stack_top_high  = stack_top[pmm_pkg::TOS_UPPER_LSB-1:pmm_pkg::TOS_HIGH_LSB];
  assign stack_top_low   = stack_top[pmm_pkg::TOS_HIGH_LSB-1:0];
endmodule // pmm_top
